// file: pkg/ifsb_cfg.svh
// register map, field masks and reset values of the flag status bank
`ifndef IFSB_CFG_SVH
`define IFSB_CFG_SVH
`define IFSB_IDX_FLAG0  4'h0
`define IFSB_IDX_FLAG1  4'h1
`define IFSB_IDX_FLAG2  4'h2
`define IFSB_IDX_FLAG3  4'h3
`define IFSB_IDX_FLAG4  4'h4
`define IFSB_IDX_ENA0   4'h5
`define IFSB_IDX_ENA4   4'h9
`define IFSB_IDX_IST    4'ha
`define IFSB_IDX_IMSK   4'hb
`define IFSB_ENA_BASE   4'h5
`define IFSB_FLAG_RST   16'h0000
`define IFSB_IRQ_RST    5'h00
`define IFSB_IMPL0      16'h0007
`define IFSB_IMPL1      16'hffdf
`define IFSB_IMPL2      16'h601f
`define IFSB_IMPL3      16'he600
`define IFSB_IMPL4      16'hce7e
`define IFSB_CAN2       16'h000c
`define IFSB_CAN4       16'h0040
`define IFSB_DAC4       16'hc000
`endif

// file: pkg/ifsb_pkg.sv
// types and shared helpers of the flag status bank
package ifsb_pkg;
  typedef enum logic [1:0] {
    IFSB_ST_IDLE = 2'b01,
    IFSB_ST_ACK  = 2'b10
  } ifsb_bus_st_t;

  typedef logic [15:0] ifsb_word_t;

  // expands the two low byte enables into a 16-bit write mask
  function automatic ifsb_word_t ifsb_be_mask(input logic [1:0] be);
    ifsb_be_mask = {{8{be[1]}}, {8{be[0]}}};
  endfunction
endpackage

// file: rtl/ifsb_flag_bank.sv
// one flag register with its companion enable register
`timescale 1ns/1ns
`include "ifsb_cfg.svh"
module ifsb_flag_bank
  import ifsb_pkg::*;
#(
  parameter ifsb_word_t IMPL = 16'hffff
) (
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  input  wire ifsb_word_t src_evt,
  input  wire logic       wr_flag,
  input  wire logic       wr_enable,
  input  wire ifsb_word_t wr_data,
  input  wire logic [1:0] wr_be,
  output ifsb_word_t      flag_q,
  output ifsb_word_t      enable_q,
  output ifsb_word_t      pend_q,
  output logic            new_req
);
  ifsb_word_t flag_reg, flag_next;
  ifsb_word_t enable_reg, enable_next;
  ifsb_word_t pend_reg;
  ifsb_word_t wmask;

  always_comb begin
    wmask     = ifsb_be_mask(wr_be);
    flag_next = flag_reg;
    if (wr_flag) begin
      flag_next = (flag_reg & ~wmask) | (wr_data & wmask);
    end
    flag_next   = (flag_next | src_evt) & IMPL;
    enable_next = enable_reg;
    if (wr_enable) begin
      enable_next = ((enable_reg & ~wmask) | (wr_data & wmask)) & IMPL;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      flag_reg <= `IFSB_FLAG_RST;
    end else begin
      flag_reg <= flag_next;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      enable_reg <= `IFSB_FLAG_RST;
    end else begin
      enable_reg <= enable_next;
    end
  end

  // request proceeds only where its enable is set
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pend_reg <= `IFSB_FLAG_RST;
    end else begin
      pend_reg <= flag_reg & enable_reg;
    end
  end

  assign new_req  = |(src_evt & IMPL & enable_reg);
  assign flag_q   = flag_reg;
  assign enable_q = enable_reg;
  assign pend_q   = pend_reg;

  AST_FLAG_SETS: assert property (@(posedge clk_sys) disable iff (!rstn)
    (|(src_evt & IMPL)) |=> ((flag_q & $past(src_evt) & IMPL) == ($past(src_evt) & IMPL)))
    else $error("source event did not set its flag");
  AST_UNIMPL_ZERO: assert property (@(posedge clk_sys) disable iff (!rstn)
    ((flag_q & ~IMPL) == 16'h0000) && ((enable_q & ~IMPL) == 16'h0000))
    else $error("unimplemented flag bit is set");
  AST_PEND_FOLLOWS: assert property (@(posedge clk_sys) disable iff (!rstn)
    ##1 (pend_q == ($past(flag_q) & $past(enable_q))))
    else $error("pending request does not match flag and enable");
endmodule

// file: rtl/ifsb_top.sv
// interrupt flag status bank with avalon-mm register access
`timescale 1ns/1ns
`include "ifsb_cfg.svh"
module ifsb_top
  import ifsb_pkg::*;
#(
  parameter bit HAS_CAN = 1'b1,
  parameter bit HAS_DAC = 1'b1
) (
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic             irq,
  output ifsb_word_t       req_pend_0,
  output ifsb_word_t       req_pend_1,
  output ifsb_word_t       req_pend_2,
  output ifsb_word_t       req_pend_3,
  output ifsb_word_t       req_pend_4,
  input  wire logic        out_compare_one_flag_set,
  input  wire logic        in_capture_one_flag_set,
  input  wire logic        ext_pin_zero_flag_set,
  input  wire logic        uart_two_tx_flag_set,
  input  wire logic        uart_two_rx_flag_set,
  input  wire logic        ext_pin_two_flag_set,
  input  wire logic        timer_five_flag_set,
  input  wire logic        timer_four_flag_set,
  input  wire logic        out_compare_four_flag_set,
  input  wire logic        out_compare_three_flag_set,
  input  wire logic        dma_ch_two_done_flag_set,
  input  wire logic        in_capture_eight_flag_set,
  input  wire logic        in_capture_seven_flag_set,
  input  wire logic        ext_pin_one_flag_set,
  input  wire logic        change_notify_flag_set,
  input  wire logic        comparator_flag_set,
  input  wire logic        i2c_master_event_flag_set,
  input  wire logic        i2c_slave_event_flag_set,
  input  wire logic        dma_ch_four_done_flag_set,
  input  wire logic        parallel_port_flag_set,
  input  wire logic        dma_ch_three_done_flag_set,
  input  wire logic        can_event_flag_set,
  input  wire logic        can_rx_ready_flag_set,
  input  wire logic        spi_two_event_flag_set,
  input  wire logic        spi_two_error_flag_set,
  input  wire logic        pwm_one_fault_flag_set,
  input  wire logic        calendar_clock_flag_set,
  input  wire logic        dma_ch_five_done_flag_set,
  input  wire logic        encoder_one_event_flag_set,
  input  wire logic        pwm_one_event_flag_set,
  input  wire logic        audio_left_flag_set,
  input  wire logic        audio_right_flag_set,
  input  wire logic        encoder_two_event_flag_set,
  input  wire logic        pwm_two_fault_flag_set,
  input  wire logic        pwm_two_event_flag_set,
  input  wire logic        can_tx_request_flag_set,
  input  wire logic        dma_ch_seven_done_flag_set,
  input  wire logic        dma_ch_six_done_flag_set,
  input  wire logic        checksum_gen_flag_set,
  input  wire logic        uart_two_error_flag_set,
  input  wire logic        uart_one_error_flag_set
);
  // variant pruning of the implemented bit masks
  localparam ifsb_word_t CAN_OFF2 = HAS_CAN ? `IFSB_FLAG_RST : `IFSB_CAN2;
  localparam ifsb_word_t CAN_OFF4 = HAS_CAN ? `IFSB_FLAG_RST : `IFSB_CAN4;
  localparam ifsb_word_t DAC_OFF4 = HAS_DAC ? `IFSB_FLAG_RST : `IFSB_DAC4;
  localparam ifsb_word_t IMPL_TAB [5] = '{
    `IFSB_IMPL0,
    `IFSB_IMPL1,
    `IFSB_IMPL2 & ~CAN_OFF2,
    `IFSB_IMPL3,
    `IFSB_IMPL4 & ~CAN_OFF4 & ~DAC_OFF4
  };

  function automatic logic [3:0] ifsb_sel(input logic [5:0] addr);
    ifsb_sel = addr[5:2];
  endfunction

  ifsb_bus_st_t st_reg;
  ifsb_word_t   evt      [5];
  ifsb_word_t   flag_w   [5];
  ifsb_word_t   enable_w [5];
  ifsb_word_t   pend_w   [5];
  logic [4:0]   new_req;
  logic [4:0]   wr_flag;
  logic [4:0]   wr_enable;
  logic [4:0]   ist_reg, ist_next;
  logic [4:0]   imsk_reg;
  logic [31:0]  rdata_reg;
  logic         irq_reg;
  logic         req_any;
  logic         wr_fire;
  logic         rd_fire;
  logic [3:0]   sel;
  logic [3:0]   wsel;
  logic [4:0]   rd_ist;
  logic [4:0]   wr_low;

  // event vectors in register bit order
  assign evt[0] = {13'h0000, out_compare_one_flag_set, in_capture_one_flag_set,
                   ext_pin_zero_flag_set};
  assign evt[1] = {uart_two_tx_flag_set, uart_two_rx_flag_set, ext_pin_two_flag_set,
                   timer_five_flag_set, timer_four_flag_set, out_compare_four_flag_set,
                   out_compare_three_flag_set, dma_ch_two_done_flag_set,
                   in_capture_eight_flag_set, in_capture_seven_flag_set, 1'b0,
                   ext_pin_one_flag_set, change_notify_flag_set, comparator_flag_set,
                   i2c_master_event_flag_set, i2c_slave_event_flag_set};
  assign evt[2] = {1'b0, dma_ch_four_done_flag_set, parallel_port_flag_set, 8'h00,
                   dma_ch_three_done_flag_set, can_event_flag_set,
                   can_rx_ready_flag_set, spi_two_event_flag_set,
                   spi_two_error_flag_set};
  assign evt[3] = {pwm_one_fault_flag_set, calendar_clock_flag_set,
                   dma_ch_five_done_flag_set, 2'b00, encoder_one_event_flag_set,
                   pwm_one_event_flag_set, 9'h000};
  assign evt[4] = {audio_left_flag_set, audio_right_flag_set, 2'b00,
                   encoder_two_event_flag_set, pwm_two_fault_flag_set,
                   pwm_two_event_flag_set, 2'b00, can_tx_request_flag_set,
                   dma_ch_seven_done_flag_set, dma_ch_six_done_flag_set,
                   checksum_gen_flag_set, uart_two_error_flag_set,
                   uart_one_error_flag_set, 1'b0};

  // bus handshake: one wait state, effects at the accepting edge
  assign req_any         = avs_read | avs_write;
  assign avs_waitrequest = req_any & (st_reg != IFSB_ST_ACK);
  assign wr_fire         = avs_write & (st_reg == IFSB_ST_ACK);
  assign rd_fire         = avs_read & (st_reg == IFSB_ST_ACK);
  assign sel             = ifsb_sel(avs_address);

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_reg <= IFSB_ST_IDLE;
    end else begin
      case (st_reg)
        IFSB_ST_IDLE: begin
          if (req_any) begin
            st_reg <= IFSB_ST_ACK;
          end
        end
        IFSB_ST_ACK: begin
          st_reg <= IFSB_ST_IDLE;
        end
        default: begin
          st_reg <= IFSB_ST_IDLE;
        end
      endcase
    end
  end

  // write strobes per bank
  always_comb begin
    wsel = sel - `IFSB_ENA_BASE;
    for (int i = 0; i < 5; i++) begin
      wr_flag[i]   = wr_fire && (sel == 4'(i));
      wr_enable[i] = wr_fire && (sel >= `IFSB_IDX_ENA0) && (sel <= `IFSB_IDX_ENA4)
                     && (wsel == 4'(i));
    end
  end

  for (genvar g = 0; g < 5; g++) begin : gen_bank
    ifsb_flag_bank #(
      .IMPL (IMPL_TAB[g])
    ) u_bank (
      .clk_sys   (clk_sys),
      .rstn      (rstn),
      .src_evt   (evt[g]),
      .wr_flag   (wr_flag[g]),
      .wr_enable (wr_enable[g]),
      .wr_data   (avs_writedata[15:0]),
      .wr_be     (avs_byteenable[1:0]),
      .flag_q    (flag_w[g]),
      .enable_q  (enable_w[g]),
      .pend_q    (pend_w[g]),
      .new_req   (new_req[g])
    );
  end

  // read data captured on the first cycle so it stands at the accepting edge
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rdata_reg <= 32'h0000_0000;
    end else if (avs_read && st_reg == IFSB_ST_IDLE) begin
      if (sel <= `IFSB_IDX_FLAG4) begin
        rdata_reg <= {16'h0000, flag_w[sel[2:0]]};
      end else if (sel <= `IFSB_IDX_ENA4) begin
        rdata_reg <= {16'h0000, enable_w[wsel[2:0]]};
      end else if (sel == `IFSB_IDX_IST) begin
        rdata_reg <= {27'h0000000, ist_reg};
      end else if (sel == `IFSB_IDX_IMSK) begin
        rdata_reg <= {27'h0000000, imsk_reg};
      end else begin
        rdata_reg <= 32'h0000_0000;
      end
    end
  end
  assign avs_readdata = rdata_reg;

  // sticky per-bank status; a read clears only what it returned, new events win
  always_comb begin
    ist_next = ist_reg;
    if (rd_fire && sel == `IFSB_IDX_IST) begin
      ist_next = ist_reg & ~rdata_reg[4:0];
    end
    ist_next = ist_next | new_req;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ist_reg <= `IFSB_IRQ_RST;
    end else begin
      ist_reg <= ist_next;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      imsk_reg <= `IFSB_IRQ_RST;
    end else if (wr_fire && sel == `IFSB_IDX_IMSK && avs_byteenable[0]) begin
      imsk_reg <= avs_writedata[4:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(ist_reg & imsk_reg);
    end
  end
  assign irq = irq_reg;

  assign req_pend_0 = pend_w[0];
  assign req_pend_1 = pend_w[1];
  assign req_pend_2 = pend_w[2];
  assign req_pend_3 = pend_w[3];
  assign req_pend_4 = pend_w[4];

  AST_ONE_WAIT: assert property (@(posedge clk_sys) disable iff (!rstn)
    (req_any && st_reg == IFSB_ST_IDLE) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus answer not after exactly one wait state");
  AST_WR_ZERO_CLEARS: assert property (@(posedge clk_sys) disable iff (!rstn)
    (wr_fire && sel == `IFSB_IDX_FLAG0 && avs_byteenable[0] && !avs_writedata[1]
     && !in_capture_one_flag_set) |=> !flag_w[0][1])
    else $error("write of zero did not clear flag");
  AST_WR_ONE_SETS: assert property (@(posedge clk_sys) disable iff (!rstn)
    (wr_fire && sel == `IFSB_IDX_FLAG1 && avs_byteenable[1] && avs_writedata[15])
    |=> flag_w[1][15])
    else $error("write of one did not set flag");
  AST_CAN_OFF: assert property (@(posedge clk_sys) disable iff (!rstn)
    !HAS_CAN |-> (flag_w[2][3:2] == 2'b00 && !flag_w[4][6]))
    else $error("can flag set on variant without can");
  AST_DAC_OFF: assert property (@(posedge clk_sys) disable iff (!rstn)
    !HAS_DAC |-> (flag_w[4][15:14] == 2'b00))
    else $error("dac flag set on variant without dac");
  AST_RSV_READ_ZERO: assert property (@(posedge clk_sys) disable iff (!rstn)
    (rd_fire && sel == `IFSB_IDX_FLAG1) |-> (avs_readdata[31:16] == 16'h0000 && !avs_readdata[5]))
    else $error("unimplemented bits read nonzero");
  AST_IRQ_LEVEL: assert property (@(posedge clk_sys) disable iff (!rstn)
    (|(ist_reg & imsk_reg)) |=> irq)
    else $error("unmasked status without interrupt");
  AST_EVT_PEND: assert property (@(posedge clk_sys) disable iff (!rstn)
    (timer_five_flag_set && enable_w[1][12]) |-> ##2 req_pend_1[12])
    else $error("enabled request did not become pending");

  // views of bus fields, read by the status and mask checks
  assign rd_ist = rdata_reg[4:0];
  assign wr_low = avs_writedata[4:0];

  AST_IDLE_NO_WAIT: assert property (@(posedge clk_sys) disable iff (!rstn)
    !req_any |-> !avs_waitrequest)
    else $error("waitrequest high without a request");
  AST_IRQ_QUIET: assert property (@(posedge clk_sys) disable iff (!rstn)
    !(|(ist_reg & imsk_reg)) |=> !irq)
    else $error("interrupt without unmasked status");
  AST_IST_SETS: assert property (@(posedge clk_sys) disable iff (!rstn)
    (|new_req) |=> ((ist_reg & $past(new_req)) == $past(new_req)))
    else $error("enabled event did not set its status bit");
  AST_IST_CLEARS: assert property (@(posedge clk_sys) disable iff (!rstn)
    (rd_fire && sel == `IFSB_IDX_IST && new_req == 5'h00)
    |=> ((ist_reg & $past(rd_ist)) == 5'h00))
    else $error("status read did not clear the returned bits");
  AST_MASK_WRITE: assert property (@(posedge clk_sys) disable iff (!rstn)
    (wr_fire && sel == `IFSB_IDX_IMSK && avs_byteenable[0])
    |=> (imsk_reg == $past(wr_low)))
    else $error("mask write did not land");
  AST_UNMAPPED_ZERO: assert property (@(posedge clk_sys) disable iff (!rstn)
    (rd_fire && sel > `IFSB_IDX_IMSK) |-> (avs_readdata == 32'h0000_0000))
    else $error("unmapped place read nonzero");

  AST_UPPER_ZERO: assert property (@(posedge clk_sys) disable iff (!rstn)
    (rd_fire && sel <= `IFSB_IDX_IMSK) |-> (avs_readdata[31:16] == 16'h0000))
    else $error("upper half of a register read nonzero");
  AST_RSV0_ZERO: assert property (@(posedge clk_sys) disable iff (!rstn)
    (rd_fire && sel == `IFSB_IDX_FLAG0) |-> ((avs_readdata[15:0] & ~`IFSB_IMPL0) == 16'h0000))
    else $error("unimplemented bit of first flag register read nonzero");
  AST_RSV2_ZERO: assert property (@(posedge clk_sys) disable iff (!rstn)
    (rd_fire && sel == `IFSB_IDX_FLAG2) |-> ((avs_readdata[15:0] & ~`IFSB_IMPL2) == 16'h0000))
    else $error("unimplemented bit of third flag register read nonzero");
  AST_RSV3_ZERO: assert property (@(posedge clk_sys) disable iff (!rstn)
    (rd_fire && sel == `IFSB_IDX_FLAG3) |-> ((avs_readdata[15:0] & ~`IFSB_IMPL3) == 16'h0000))
    else $error("unimplemented bit of fourth flag register read nonzero");
  AST_RSV4_ZERO: assert property (@(posedge clk_sys) disable iff (!rstn)
    (rd_fire && sel == `IFSB_IDX_FLAG4) |-> ((avs_readdata[15:0] & ~`IFSB_IMPL4) == 16'h0000))
    else $error("unimplemented bit of fifth flag register read nonzero");

  AST_MAP_EXT0: assert property (@(posedge clk_sys) disable iff (!rstn)
    ext_pin_zero_flag_set |=> flag_w[0][0])
    else $error("external pin 0 event not at its flag");
  AST_MAP_UART_TX: assert property (@(posedge clk_sys) disable iff (!rstn)
    uart_two_tx_flag_set |=> flag_w[1][15])
    else $error("uart 2 transmit event not at its flag");
  AST_MAP_I2C_SLAVE: assert property (@(posedge clk_sys) disable iff (!rstn)
    i2c_slave_event_flag_set |=> flag_w[1][0])
    else $error("i2c slave event not at its flag");
  AST_MAP_SPI_ERR: assert property (@(posedge clk_sys) disable iff (!rstn)
    spi_two_error_flag_set |=> flag_w[2][0])
    else $error("spi 2 error event not at its flag");
  AST_MAP_FAULT1: assert property (@(posedge clk_sys) disable iff (!rstn)
    pwm_one_fault_flag_set |=> flag_w[3][15])
    else $error("pwm 1 fault event not at its flag");
  AST_MAP_ENC2: assert property (@(posedge clk_sys) disable iff (!rstn)
    encoder_two_event_flag_set |=> flag_w[4][11])
    else $error("encoder 2 event not at its flag");
  AST_MAP_UART1_ERR: assert property (@(posedge clk_sys) disable iff (!rstn)
    uart_one_error_flag_set |=> flag_w[4][1])
    else $error("uart 1 error event not at its flag");

  AST_PEND_NEEDS_ENABLE: assert property (@(posedge clk_sys) disable iff (!rstn)
    (enable_w[3] == 16'h0000) |=> (req_pend_3 == 16'h0000))
    else $error("request pending without its enable");
endmodule

// file: sim/ifsb_src_model.sv
// peripheral sources that raise one-cycle interrupt request pulses
`timescale 1ns/1ns
module ifsb_src_model (
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic        fire,
  input  wire logic [6:0]  fire_idx,
  output logic      [79:0] evt
);
  // bit index is bank * 16 + flag position
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      evt <= 80'h0;
    end else begin
      evt <= fire ? (80'h1 << fire_idx) : 80'h0;
    end
  end
endmodule

// file: sim/tb_top.sv
// self-checking bench for the interrupt flag status bank
`timescale 1ns/1ns
module tb_top
  import ifsb_pkg::*;
;
  logic        clk_sys;
  logic        rstn;
  logic [5:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] rdata [2];
  logic        wreq [2];
  logic        irq_o [2];
  ifsb_word_t  pend [2][5];
  logic        fire;
  logic [6:0]  fire_idx;
  logic [79:0] evt;
  int          num_errors;
  int          compares;
  logic [31:0] rd0;
  logic [31:0] rd1;
  ifsb_word_t  m0 [5];
  ifsb_word_t  m1 [5];

  ifsb_src_model src (.clk_sys(clk_sys), .rstn(rstn), .fire(fire), .fire_idx(fire_idx),
    .evt(evt));

  // instance 0 is the full variant, instance 1 lacks can and audio dac
  for (genvar g = 0; g < 2; g++) begin : g_dut
    ifsb_top #(.HAS_CAN(1'(g == 0)), .HAS_DAC(1'(g == 0))) DUT (
      .clk_sys(clk_sys), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(rdata[g]), .avs_waitrequest(wreq[g]), .irq(irq_o[g]),
      .req_pend_0(pend[g][0]), .req_pend_1(pend[g][1]), .req_pend_2(pend[g][2]),
      .req_pend_3(pend[g][3]), .req_pend_4(pend[g][4]),
      .ext_pin_zero_flag_set(evt[0]), .in_capture_one_flag_set(evt[1]),
      .out_compare_one_flag_set(evt[2]), .i2c_slave_event_flag_set(evt[16]),
      .i2c_master_event_flag_set(evt[17]), .comparator_flag_set(evt[18]),
      .change_notify_flag_set(evt[19]), .ext_pin_one_flag_set(evt[20]),
      .in_capture_seven_flag_set(evt[22]), .in_capture_eight_flag_set(evt[23]),
      .dma_ch_two_done_flag_set(evt[24]), .out_compare_three_flag_set(evt[25]),
      .out_compare_four_flag_set(evt[26]), .timer_four_flag_set(evt[27]),
      .timer_five_flag_set(evt[28]), .ext_pin_two_flag_set(evt[29]),
      .uart_two_rx_flag_set(evt[30]), .uart_two_tx_flag_set(evt[31]),
      .spi_two_error_flag_set(evt[32]), .spi_two_event_flag_set(evt[33]),
      .can_rx_ready_flag_set(evt[34]), .can_event_flag_set(evt[35]),
      .dma_ch_three_done_flag_set(evt[36]), .parallel_port_flag_set(evt[45]),
      .dma_ch_four_done_flag_set(evt[46]), .pwm_one_event_flag_set(evt[57]),
      .encoder_one_event_flag_set(evt[58]), .dma_ch_five_done_flag_set(evt[61]),
      .calendar_clock_flag_set(evt[62]), .pwm_one_fault_flag_set(evt[63]),
      .uart_one_error_flag_set(evt[65]), .uart_two_error_flag_set(evt[66]),
      .checksum_gen_flag_set(evt[67]), .dma_ch_six_done_flag_set(evt[68]),
      .dma_ch_seven_done_flag_set(evt[69]), .can_tx_request_flag_set(evt[70]),
      .pwm_two_event_flag_set(evt[73]), .pwm_two_fault_flag_set(evt[74]),
      .encoder_two_event_flag_set(evt[75]), .audio_right_flag_set(evt[78]),
      .audio_left_flag_set(evt[79]));
  end

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one avalon access; both instances see it and answer in step
  task automatic bus(input logic wr, input logic [5:0] addr, input logic [15:0] data,
                     input logic [3:0] be);
    @(posedge clk_sys);
    avs_address    <= addr;
    avs_read       <= !wr;
    avs_write      <= wr;
    avs_writedata  <= {16'h0000, data};
    avs_byteenable <= be;
    do @(posedge clk_sys); while (wreq[0] !== 1'b0);
    rd0 = rdata[0];
    rd1 = rdata[1];
    chk({31'h0, wreq[1]}, 32'h0);
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic pulse(input int idx);
    @(posedge clk_sys);
    fire     <= 1'b1;
    fire_idx <= 7'(idx);
    @(posedge clk_sys);
    fire <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask

  task automatic complete_run;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    num_errors++;
    $display("mismatch at %0t: run timed out", $time);
    complete_run;
  end

  initial begin
    m0 = '{16'h0007, 16'hffdf, 16'h601f, 16'he600, 16'hce7e};
    m1 = '{16'h0007, 16'hffdf, 16'h6013, 16'he600, 16'h0e3e};
    num_errors = 0;
    compares = 0;
    rstn = 1'b0;
    avs_address = 6'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    fire = 1'b0;
    fire_idx = 7'h00;
    repeat (4) @(posedge clk_sys);
    rstn <= 1'b1;
    for (int a = 0; a < 12; a++) begin
      bus(1'b0, 6'(a * 4), 16'h0000, 4'hf);
      chk(rd0, 32'h0);
    end
    chk({31'h0, irq_o[0]}, 32'h0);
    for (int b = 0; b < 5; b++) begin
      bus(1'b1, 6'(b * 4), 16'hffff, 4'hf);
      bus(1'b0, 6'(b * 4), 16'h0000, 4'hf);
      chk(rd0, {16'h0, m0[b]});
      chk(rd1, {16'h0, m1[b]});
      bus(1'b1, 6'(b * 4), 16'h0000, 4'hf);
      bus(1'b0, 6'(b * 4), 16'h0000, 4'hf);
      chk(rd0, 32'h0);
      // enables are clear here, so each event must still set its flag
      for (int i = 0; i < 16; i++) begin
        if (m0[b][i]) begin
          pulse(b * 16 + i);
          bus(1'b0, 6'(b * 4), 16'h0000, 4'hf);
          chk(rd0, {16'h0, 16'h0001 << i});
          chk(rd1, {16'h0, (16'h0001 << i) & m1[b]});
          bus(1'b1, 6'(b * 4), 16'h0000, 4'hf);
        end
      end
    end
    // byte lanes write independently
    bus(1'b1, 6'h04, 16'hffff, 4'h1);
    bus(1'b0, 6'h04, 16'h0000, 4'hf);
    chk(rd0, 32'h000000df);
    bus(1'b1, 6'h04, 16'hffff, 4'h2);
    bus(1'b1, 6'h04, 16'h0000, 4'h1);
    bus(1'b0, 6'h04, 16'h0000, 4'hf);
    chk(rd0, 32'h0000ff00);
    bus(1'b1, 6'h04, 16'h0000, 4'hf);
    // enabled and unmasked request raises irq; status read clears it
    bus(1'b1, 6'h18, 16'h0001, 4'hf);
    bus(1'b1, 6'h2c, 16'h0002, 4'hf);
    bus(1'b0, 6'h2c, 16'h0000, 4'hf);
    chk(rd0, 32'h2);
    pulse(16);
    chk({31'h0, irq_o[0]}, 32'h1);
    chk({16'h0, pend[0][1]}, 32'h1);
    bus(1'b0, 6'h28, 16'h0000, 4'hf);
    chk(rd0, 32'h2);
    repeat (2) @(posedge clk_sys);
    chk({31'h0, irq_o[0]}, 32'h0);
    bus(1'b0, 6'h28, 16'h0000, 4'hf);
    chk(rd0, 32'h0);
    // masked out: status still records, irq stays low
    bus(1'b1, 6'h2c, 16'h0000, 4'hf);
    pulse(16);
    chk({31'h0, irq_o[0]}, 32'h0);
    bus(1'b0, 6'h28, 16'h0000, 4'hf);
    chk(rd0, 32'h2);
    bus(1'b1, 6'h04, 16'h0000, 4'hf);
    repeat (2) @(posedge clk_sys);
    chk({16'h0, pend[0][1]}, 32'h0);
    // unmapped place reads zero and ignores writes
    bus(1'b1, 6'h30, 16'hffff, 4'hf);
    bus(1'b0, 6'h30, 16'h0000, 4'hf);
    chk(rd0, 32'h0);
    // every enable and pending output follows the implemented masks
    for (int b = 0; b < 5; b++) begin
      bus(1'b1, 6'(b * 4 + 20), 16'hffff, 4'hf);
      bus(1'b0, 6'(b * 4 + 20), 16'h0000, 4'hf);
      chk(rd0, {16'h0, m0[b]});
      chk(rd1, {16'h0, m1[b]});
      bus(1'b1, 6'(b * 4), 16'hffff, 4'hf);
      repeat (2) @(posedge clk_sys);
      chk({16'h0, pend[0][b]}, {16'h0, m0[b]});
      chk({16'h0, pend[1][b]}, {16'h0, m1[b]});
      bus(1'b1, 6'(b * 4), 16'h0000, 4'hf);
    end
    // enabled events set status while masked; the second variant has no can
    pulse(28);
    pulse(35);
    chk({16'h0, pend[0][1]}, 32'h1000);
    chk({16'h0, pend[0][2]}, 32'h0008);
    chk({16'h0, pend[1][2]}, 32'h0);
    chk({31'h0, irq_o[0]}, 32'h0);
    chk({31'h0, irq_o[1]}, 32'h0);
    bus(1'b0, 6'h28, 16'h0000, 4'hf);
    chk(rd0, 32'h6);
    chk(rd1, 32'h2);
    complete_run;
  end
endmodule
